// *** verilog/rsm_map.svh ***
/*
  Register offsets, field positions, masks and reset values of the runtime
  enable, miscellaneous status, forced media change and shadow registers.
  Assumes an 8-bit offset space and 8-bit registers.
*/
`ifndef RSM_MAP_SVH
`define RSM_MAP_SVH

// Register offsets
`define RSM_OFS_STS_C 8'h12
`define RSM_OFS_STS_D 8'h13
`define RSM_OFS_STS_E 8'h14
`define RSM_OFS_ROUTE 8'h17
`define RSM_OFS_EN_C 8'h18
`define RSM_OFS_EN_D 8'h19
`define RSM_OFS_EN_E 8'h1A
`define RSM_OFS_RSV_1B 8'h1B
`define RSM_OFS_MISC 8'h1C
`define RSM_OFS_RSV_1D 8'h1D
`define RSM_OFS_FORCE 8'h1E
`define RSM_OFS_FDC_SHD 8'h1F
`define RSM_OFS_SER1_SHD 8'h20

// Implemented bits per register; the rest read as zero
`define RSM_MASK_C 8'hF7
`define RSM_MASK_D 8'hFF
`define RSM_MASK_E 8'hCF
`define RSM_MASK_ROUTE 8'hE0
`define RSM_MASK_MISC 8'h3F
`define RSM_MASK_FORCE 8'h03
`define RSM_MASK_FDC 8'hDF
`define RSM_MASK_SER 8'hCF

// Field positions
`define RSM_ROUTE_PME 5
`define RSM_ROUTE_SERIRQ 6
`define RSM_ROUTE_PIN 7
`define RSM_FORCE_DRV0 0
`define RSM_FORCE_DRV1 1

// Reset values
`define RSM_RST_EN 8'h00
`define RSM_RST_STS 8'h00
`define RSM_RST_MISC 8'h00
`define RSM_RST_FORCE 8'h01
`define RSM_RST_SHD 8'h00

`endif

// *** verilog/rsm_pkg.sv ***
/*
  Types shared by the runtime register slice: bus request, pin groups and
  shadow capture strobes.
  Assumes the offsets and masks come from rsm_map.svh.
*/
package rsm_pkg;

  // One register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rsm_bus_req_t;

  // General purpose pins watched by this slice, most significant first
  typedef struct packed {
    logic gpio_pin_20;
    logic gpio_pin_21;
    logic gpio_pin_22;
    logic gpio_pin_24;
    logic gpio_pin_25;
    logic gpio_pin_26;
    logic gpio_pin_60;
    logic gpio_pin_30;
    logic gpio_pin_31;
    logic gpio_pin_32;
    logic gpio_pin_33;
    logic gpio_pin_41;
    logic gpio_pin_42;
    logic gpio_pin_43;
    logic gpio_pin_61;
    logic gpio_pin_54;
    logic gpio_pin_55;
    logic gpio_pin_56;
    logic gpio_pin_57;
  } rsm_gpio_t;

  // Floppy drive interface pins, all active low
  typedef struct packed {
    logic head_step_n;
    logic drive_select_0_n;
    logic drive_select_1_n;
    logic media_changed_in_n;
  } rsm_fdd_t;

  // Write of a write-only control register elsewhere in the chip
  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } rsm_shd_wr_t;

endpackage : rsm_pkg

// *** verilog/rsm_pin_sync.sv ***
/*
  Two-flop synchroniser with edge detection for a vector of pins.
  Assumes asynchronous pin inputs and a single clock with synchronous reset.
*/
`timescale 1ns/10ps
module rsm_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Raw pins
  input wire logic [WIDTH-1:0] pin_in,
  // Synchronised level and edge pulses
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out,
  output logic [WIDTH-1:0] fall_out
);

  logic [WIDTH-1:0] meta_r; // First stage, read only by the second
  logic [WIDTH-1:0] sync_r; // Second stage, safe level
  logic [WIDTH-1:0] prev_r; // Previous safe level for edges

  // Synchroniser chain; reset to zero so no edge is reported before real data
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edges come from the two safe stages only
  assign level_out = sync_r;
  assign rise_out = sync_r & ~prev_r;
  assign fall_out = ~sync_r & prev_r;

endmodule : rsm_pin_sync

// *** verilog/rsm_regs.sv ***
/*
  Runtime register slice: management interrupt source enables and status,
  interrupt routing, either-edge miscellaneous status, forced media change
  flags and the floppy rate and first serial FIFO control shadows.
  Assumes a plain register port on ref_clk_in, pins arriving asynchronously,
  and shadow write strobes coming from logic on the same clock.
*/
`timescale 1ns/10ps
`include "rsm_map.svh"
module rsm_regs (
  // Clock and resets
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic main_rst_in,
  // Register port
  input wire rsm_pkg::rsm_bus_req_t bus_in,
  output logic [7:0] rdata_out,
  // Pins
  input wire rsm_pkg::rsm_gpio_t gpio_in,
  input wire rsm_pkg::rsm_fdd_t fdd_in,
  // Fan speed events from same-clock logic
  input wire logic fan_speed_event_1_in,
  input wire logic fan_speed_event_2_in,
  // Shadow capture strobes from same-clock logic
  input wire rsm_pkg::rsm_shd_wr_t fdc_rate_wr_in,
  input wire rsm_pkg::rsm_shd_wr_t serial1_fcr_wr_in,
  // Interrupt and routing outputs
  output logic group_irq_out,
  output logic mgmt_irq_pin_n_out,
  output logic serirq_mgmt_req_out,
  output logic pme_mgmt_req_out,
  // Floppy controller input register bit 7
  output logic media_changed_bit_out
);

  // Width of the watched general purpose pin group
  localparam int PINS = $bits(rsm_pkg::rsm_gpio_t);

  // Synchronised pin views; the general purpose pin levels themselves are never needed
  logic [PINS-1:0] gp_rise_v; // Rising edge pulses
  logic [PINS-1:0] gp_fall_v; // Falling edge pulses
  rsm_pkg::rsm_gpio_t gp_rise; // Rising edges by pin name
  rsm_pkg::rsm_gpio_t gp_edge; // Either edge by pin name
  logic [3:0] fdd_lvl; // Safe floppy levels, inverted to active high
  logic [3:0] fdd_fall; // Falling edges of the raw floppy pins
  rsm_pkg::rsm_fdd_t fdd_s; // Safe floppy levels by name
  rsm_pkg::rsm_fdd_t fdd_f; // Falling edges by name

  // Register state
  logic [7:0] sts_r [3]; // Source status c, d, e
  logic [7:0] en_r [3]; // Source enable c, d, e
  logic [7:0] sts_set [3]; // Hardware set vectors
  logic [7:0] sts_mask [3]; // Implemented bits
  logic [7:0] sts_ofs [3]; // Status offsets
  logic [7:0] en_ofs [3]; // Enable offsets
  logic [7:0] route_r; // Routing bits 7:5
  logic [7:0] misc_r; // Either-edge status
  logic [7:0] misc_set; // Either-edge set vector
  logic [7:0] force_r; // Forced media change flags
  logic [7:0] force_clr; // Hardware clear of force flags
  logic [7:0] fdc_shd_r; // Floppy rate shadow
  logic [7:0] ser_shd_r; // First serial FIFO control shadow
  logic [7:0] rdata_r; // Read data held for one cycle
  logic [7:0] rdata_nxt; // Read mux output
  logic irq_r; // Registered group interrupt
  logic irq_nxt; // Any enabled status pending
  logic route_pin_r; // Routed pin output, active low
  logic route_ser_r; // Routed serial request
  logic route_pme_r; // Routed wake request
  logic media_r; // Registered media changed bit
  logic media_nxt; // Media changed combination
  logic wr_hit_misc; // Write to misc status
  logic wr_hit_force; // Write to force flags
  logic wr_hit_route; // Write to routing bits

  // General purpose pins are asynchronous, so all go through one synchroniser bank
  // An edge reaches the status registers three cycles after the pin moves
  rsm_pin_sync #(
    .WIDTH(PINS)
  ) u_gpio_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .pin_in(gpio_in),
    .level_out(),
    .rise_out(gp_rise_v),
    .fall_out(gp_fall_v)
  );

  // Floppy pins use the same cell; reset under main power like the flags
  // They are inverted on the way in, so the cell's zero reset level is the
  // idle level of these active-low lines: no false select or edge after reset
  rsm_pin_sync #(
    .WIDTH(4)
  ) u_fdd_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in(main_rst_in),
    .pin_in(~fdd_in),
    .level_out(fdd_lvl),
    .rise_out(fdd_fall),
    .fall_out()
  );

  // Named views of the edge vectors
  assign gp_rise = gp_rise_v;
  assign gp_edge = gp_rise_v | gp_fall_v;
  // Back to the active-low form of the pins; a rise inside is a pin fall
  assign fdd_s = ~fdd_lvl;
  assign fdd_f = fdd_fall;

  // Status c sources; bit 3 has no source
  assign sts_set[0] = {gp_rise.gpio_pin_60, gp_rise.gpio_pin_26,
                       gp_rise.gpio_pin_25, gp_rise.gpio_pin_24, 1'b0,
                       gp_rise.gpio_pin_22, gp_rise.gpio_pin_21,
                       gp_rise.gpio_pin_20};
  // Status d sources in bit order 7 to 0
  assign sts_set[1] = {gp_rise.gpio_pin_61, gp_rise.gpio_pin_43,
                       gp_rise.gpio_pin_42, gp_rise.gpio_pin_41,
                       gp_rise.gpio_pin_33, gp_rise.gpio_pin_32,
                       gp_rise.gpio_pin_31, gp_rise.gpio_pin_30};
  // Status e sources; fan events already on this clock, bits 5:4 empty
  assign sts_set[2] = {fan_speed_event_2_in, fan_speed_event_1_in,
                       2'b00, gp_rise.gpio_pin_57, gp_rise.gpio_pin_56,
                       gp_rise.gpio_pin_55, gp_rise.gpio_pin_54};

  // Per-group constants, so that one generate loop serves all three groups
  assign sts_mask[0] = `RSM_MASK_C;
  assign sts_mask[1] = `RSM_MASK_D;
  assign sts_mask[2] = `RSM_MASK_E;
  assign sts_ofs[0] = `RSM_OFS_STS_C;
  assign sts_ofs[1] = `RSM_OFS_STS_D;
  assign sts_ofs[2] = `RSM_OFS_STS_E;
  assign en_ofs[0] = `RSM_OFS_EN_C;
  assign en_ofs[1] = `RSM_OFS_EN_D;
  assign en_ofs[2] = `RSM_OFS_EN_E;

  // One status and one enable register per source group
  for (genvar g = 0; g < 3; g++) begin : g_src
    // Enable: plain read/write, reserved bits held at zero
    // Enables share the status mask, so a reserved bit can never be enabled
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        // All sources start disabled
        en_r[g] <= `RSM_RST_EN;
      end else if (bus_in.wr && bus_in.addr == en_ofs[g]) begin
        // Software write of this group's enables
        en_r[g] <= bus_in.wdata & sts_mask[g];
      end
    end

    // Status: write one clears, a set in the same cycle wins,
    // so that an edge arriving during a clear is never lost
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        sts_r[g] <= `RSM_RST_STS;
      end else begin
        if (bus_in.wr && bus_in.addr == sts_ofs[g]) begin
          // Ones clear, zeros keep; new edges still set
          sts_r[g] <= ((sts_r[g] & ~bus_in.wdata) | sts_set[g]) & sts_mask[g];
        end else begin
          // No write: edges only accumulate
          sts_r[g] <= (sts_r[g] | sts_set[g]) & sts_mask[g];
        end
      end
    end
  end

  // Misc status: either edge on pins 21, 22, 41, 43, 60, 61
  // Bits 7:6 have no source and are masked off as well
  assign misc_set = {2'b00, gp_edge.gpio_pin_61, gp_edge.gpio_pin_60,
                     gp_edge.gpio_pin_43, gp_edge.gpio_pin_41,
                     gp_edge.gpio_pin_22, gp_edge.gpio_pin_21};

  // Write decodes for the single-register processes below
  assign wr_hit_misc = bus_in.wr && bus_in.addr == `RSM_OFS_MISC;
  assign wr_hit_force = bus_in.wr && bus_in.addr == `RSM_OFS_FORCE;
  assign wr_hit_route = bus_in.wr && bus_in.addr == `RSM_OFS_ROUTE;

  // Misc status register under standby reset
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      // Standby reset clears it; main power reset does not
      misc_r <= `RSM_RST_MISC;
    end else if (wr_hit_misc) begin
      // Clear by one, zero leaves the bit; a new edge beats the clear
      misc_r <= ((misc_r & ~bus_in.wdata) | misc_set) & `RSM_MASK_MISC;
    end else begin
      // No write: edges only accumulate
      misc_r <= (misc_r | misc_set) & `RSM_MASK_MISC;
    end
  end

  // Routing bits for the group interrupt
  // Only bits 7:5 exist; the lower bits read back as zero
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      // Nothing routed until software asks
      route_r <= `RSM_RST_EN;
    end else if (wr_hit_route) begin
      route_r <= bus_in.wdata & `RSM_MASK_ROUTE;
    end
  end

  // Step pulse while a drive is selected clears that drive's flag
  // The pulse is the falling edge of the active-low step line; a step
  // shorter than one clock may be missed by the synchroniser
  always_comb begin
    force_clr = 8'h00;
    force_clr[`RSM_FORCE_DRV0] = fdd_f.head_step_n & ~fdd_s.drive_select_0_n;
    force_clr[`RSM_FORCE_DRV1] = fdd_f.head_step_n & ~fdd_s.drive_select_1_n;
  end

  // Force flags live under main power reset
  always_ff @(posedge ref_clk_in) begin
    if (main_rst_in) begin
      // Drive 0 flagged after power-up, drive 1 clear
      force_r <= `RSM_RST_FORCE;
    end else if (wr_hit_force) begin
      // Software may only set; its set wins over a step in the same cycle
      force_r <= ((force_r & ~force_clr) | bus_in.wdata) & `RSM_MASK_FORCE;
    end else begin
      // No write: only drive activity can clear a flag
      force_r <= force_r & ~force_clr & `RSM_MASK_FORCE;
    end
  end

  // Media changed seen by the floppy controller, active high
  assign media_nxt = (~fdd_s.drive_select_0_n & force_r[`RSM_FORCE_DRV0]) |
                     (~fdd_s.drive_select_1_n & force_r[`RSM_FORCE_DRV1]) |
                     ~fdd_s.media_changed_in_n;

  // Registered so the controller never reads a half-settled combination
  always_ff @(posedge ref_clk_in) begin
    if (main_rst_in) begin
      // No change reported while main power comes up
      media_r <= 1'b0;
    end else begin
      media_r <= media_nxt;
    end
  end

  // Floppy rate shadow: last write to the write-only rate register
  // Read-only copy; the register port cannot write it, and bit 5 is masked
  always_ff @(posedge ref_clk_in) begin
    if (main_rst_in) begin
      fdc_shd_r <= `RSM_RST_SHD;
    end else if (fdc_rate_wr_in.wr) begin
      // Capture only on the strobe; reading the copy has no side effect
      fdc_shd_r <= fdc_rate_wr_in.data & `RSM_MASK_FDC;
    end
  end

  // First serial FIFO control shadow
  // Bits 5:4 are masked so that they always read zero
  always_ff @(posedge ref_clk_in) begin
    if (main_rst_in) begin
      ser_shd_r <= `RSM_RST_SHD;
    end else if (serial1_fcr_wr_in.wr) begin
      // Capture only on the strobe; reading the copy has no side effect
      ser_shd_r <= serial1_fcr_wr_in.data & `RSM_MASK_SER;
    end
  end

  // Group interrupt: any status bit with its enable set
  // Reserved bits are zero in both status and enable, so they never count
  assign irq_nxt = |(sts_r[0] & en_r[0]) |
                   |(sts_r[1] & en_r[1]) |
                   |(sts_r[2] & en_r[2]);

  // Registered so the outputs never glitch while bits change;
  // the price is one cycle between a status bit and the interrupt
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      // Pin idles high, requests idle low
      irq_r <= 1'b0;
      route_pin_r <= 1'b1;
      route_ser_r <= 1'b0;
      route_pme_r <= 1'b0;
    end else begin
      // Each route bit gates the same pending condition
      irq_r <= irq_nxt;
      route_pin_r <= ~(irq_nxt & route_r[`RSM_ROUTE_PIN]);
      route_ser_r <= irq_nxt & route_r[`RSM_ROUTE_SERIRQ];
      route_pme_r <= irq_nxt & route_r[`RSM_ROUTE_PME];
    end
  end

  // Read mux; reads never change state, unmapped offsets return zero
  // Shadows and reserved offsets have no write path, so they are read-only
  always_comb begin
    case (bus_in.addr)
      `RSM_OFS_STS_C: rdata_nxt = sts_r[0];
      `RSM_OFS_STS_D: rdata_nxt = sts_r[1];
      `RSM_OFS_STS_E: rdata_nxt = sts_r[2];
      `RSM_OFS_ROUTE: rdata_nxt = route_r;
      `RSM_OFS_EN_C: rdata_nxt = en_r[0];
      `RSM_OFS_EN_D: rdata_nxt = en_r[1];
      `RSM_OFS_EN_E: rdata_nxt = en_r[2];
      `RSM_OFS_RSV_1B: rdata_nxt = 8'h00;
      `RSM_OFS_MISC: rdata_nxt = misc_r;
      `RSM_OFS_RSV_1D: rdata_nxt = 8'h00;
      `RSM_OFS_FORCE: rdata_nxt = force_r;
      `RSM_OFS_FDC_SHD: rdata_nxt = fdc_shd_r;
      `RSM_OFS_SER1_SHD: rdata_nxt = ser_shd_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_r <= 8'h00;
    end else if (bus_in.rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      // Zero outside the data cycle, so stale data never lingers
      rdata_r <= 8'h00;
    end
  end

  // Output drive
  assign rdata_out = rdata_r;
  assign group_irq_out = irq_r;
  assign mgmt_irq_pin_n_out = route_pin_r;
  assign serirq_mgmt_req_out = route_ser_r;
  assign pme_mgmt_req_out = route_pme_r;
  assign media_changed_bit_out = media_r;

endmodule : rsm_regs

// *** dv/rsm_fdd_model.sv ***
/* Floppy drive side model: turns bench commands into active-low drive pins.
   Assumes the bench drives its commands by NBA at the clock edge. */
`timescale 1ns/10ps
module rsm_fdd_model (
  // Commands from the bench
  input wire logic [1:0] sel_in,
  input wire logic step_in,
  input wire logic chg_in,
  // Drive cable pins
  output rsm_pkg::rsm_fdd_t fdd_out
);
  // Changed line is open collector, so it floats high while no drive is selected
  assign fdd_out = {~step_in, ~sel_in[0], ~sel_in[1], ~(chg_in && |sel_in)};
endmodule : rsm_fdd_model

// *** dv/rsm_regs_checker.sv ***
/* Port checker of the runtime register slice.
   Assumes it is bound to rsm_regs and sees only its ports. */
`timescale 1ns/10ps
module rsm_regs_checker (
  // Clock and resets
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic main_rst_in,
  // Register port
  input wire rsm_pkg::rsm_bus_req_t bus_in,
  input wire logic [7:0] rdata_out,
  // Pins and outputs
  input wire rsm_pkg::rsm_fdd_t fdd_in,
  input wire logic group_irq_out,
  input wire logic mgmt_irq_pin_n_out,
  input wire logic serirq_mgmt_req_out,
  input wire logic pme_mgmt_req_out,
  input wire logic media_changed_bit_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  rsvd_read_a:
    assert property (bus_in.rd && (bus_in.addr == 8'h1B || bus_in.addr == 8'h1D) |=> rdata_out == 8'h00)
      else $error("reserved offset read nonzero");
  unmap_read_a:
    assert property (bus_in.rd && bus_in.addr > 8'h20 |=> rdata_out == 8'h00) else $error("unmapped read nonzero");
  misc_top_a:
    assert property (bus_in.rd && bus_in.addr == 8'h1C |=> rdata_out[7:6] == 2'h0) else $error("misc top bits set");
  force_top_a:
    assert property (bus_in.rd && bus_in.addr == 8'h1E |=> rdata_out[7:2] == 6'h00) else $error("force top bits set");
  rate_rsvd_a:
    assert property (bus_in.rd && bus_in.addr == 8'h1F |=> !rdata_out[5]) else $error("rate shadow bit5 set");
  fifo_rsvd_a:
    assert property (bus_in.rd && bus_in.addr == 8'h20 |=> rdata_out[5:4] == 2'h0) else $error("fifo shadow bits set");
  pin_route_a:
    assert property (!mgmt_irq_pin_n_out |-> group_irq_out) else $error("pin low without interrupt");
  req_route_a:
    assert property (serirq_mgmt_req_out || pme_mgmt_req_out |-> group_irq_out) else $error("request without interrupt");
  irq_fall_a:
    assert property ($fell(group_irq_out) |-> $past(bus_in.wr, 2) || $past(rst_in)) else $error("interrupt fell unasked");
  media_on_a:
    assert property (disable iff (rst_in || main_rst_in) (!fdd_in.media_changed_in_n) [*5] |-> media_changed_bit_out)
      else $error("media bit missing");
  media_off_a:
    assert property (disable iff (rst_in || main_rst_in)
      (fdd_in.drive_select_0_n && fdd_in.drive_select_1_n && fdd_in.media_changed_in_n) [*5] |-> !media_changed_bit_out)
      else $error("media bit without cause");
  // Main scenarios reached
  irq_seen_c: cover property ($rose(group_irq_out));
  pin_seen_c: cover property ($fell(mgmt_irq_pin_n_out));
  media_seen_c: cover property ($rose(media_changed_bit_out));
endmodule : rsm_regs_checker

// *** dv/tb.sv ***
/* Self-checking bench of the runtime register slice.
   Assumes the package, the slice, the drive model and the checker are compiled first. */
`timescale 1ns/10ps
module tb;
  // Clock, resets and design inputs
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic main_rst_in = 1'b1;
  rsm_pkg::rsm_bus_req_t bus = '0;
  rsm_pkg::rsm_gpio_t gpio = '0;
  rsm_pkg::rsm_fdd_t fdd;
  rsm_pkg::rsm_shd_wr_t fdc_wr = '0;
  rsm_pkg::rsm_shd_wr_t ser_wr = '0;
  logic fan1 = 1'b0;
  logic fan2 = 1'b0;
  logic [1:0] sel = 2'h0;
  logic step = 1'b0;
  logic chg = 1'b0;
  // Design outputs
  logic [7:0] rdata;
  logic irq, pin_n, serirq, pme, media;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  always #20 ref_clk_in = ~ref_clk_in;
  rsm_fdd_model i_fdd (.sel_in(sel), .step_in(step), .chg_in(chg), .fdd_out(fdd));
  rsm_regs i_dut (.ref_clk_in, .rst_in, .main_rst_in, .bus_in(bus), .rdata_out(rdata), .gpio_in(gpio),
    .fdd_in(fdd), .fan_speed_event_1_in(fan1), .fan_speed_event_2_in(fan2), .fdc_rate_wr_in(fdc_wr),
    .serial1_fcr_wr_in(ser_wr), .group_irq_out(irq), .mgmt_irq_pin_n_out(pin_n),
    .serirq_mgmt_req_out(serirq), .pme_mgmt_req_out(pme), .media_changed_bit_out(media));
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // Cut a hang short; the full run needs about four hundred cycles
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cy(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : cy
  // One-cycle write; the strobe drops at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cy(1);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    cy(1);
    bus.wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    cy(1);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    cy(1);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rdc
  task automatic t_reset();
    rdc(8'h18, 8'h00);
    rdc(8'h19, 8'h00);
    rdc(8'h1A, 8'h00);
    rdc(8'h1C, 8'h00);
    rdc(8'h1E, 8'h01);
    rdc(8'h12, 8'h00);
    rdc(8'h13, 8'h00);
    rdc(8'h14, 8'h00);
  endtask : t_reset
  task automatic t_enables();
    logic [7:0] ofs[5] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1D};
    logic [7:0] msk[5] = '{8'hF7, 8'hFF, 8'hCF, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      wr(ofs[i], 8'hFF);
      rdc(ofs[i], msk[i]);
      wr(ofs[i], 8'h5A);
      rdc(ofs[i], 8'h5A & msk[i]);
      wr(ofs[i], 8'h00);
    end
    wr(8'h40, 8'hFF);
    rdc(8'h40, 8'h00);
  endtask : t_enables
  task automatic t_misc();
    int pos[6] = '{17, 16, 7, 5, 12, 4};
    for (int i = 0; i < 6; i++) begin
      cy(1);
      gpio[pos[i]] <= 1'b1;
      cy(5);
      rdc(8'h1C, 8'(1 << i));
      wr(8'h1C, ~8'(1 << i));
      rdc(8'h1C, 8'(1 << i));
      wr(8'h1C, 8'(1 << i));
      rdc(8'h1C, 8'h00);
      cy(1);
      gpio[pos[i]] <= 1'b0;
      cy(5);
      rdc(8'h1C, 8'(1 << i));
      wr(8'h1C, 8'hFF);
      rdc(8'h1C, 8'h00);
    end
  endtask : t_misc
  task automatic t_irq();
    wr(8'h18, 8'h01);
    cy(3);
    #1 chk(8'(irq), 8'h00);
    cy(1);
    gpio.gpio_pin_20 <= 1'b1;
    cy(6);
    #1 chk(8'(irq), 8'h01);
    wr(8'h17, 8'hE0);
    cy(2);
    #1 chk({pin_n, serirq, pme, 5'h00}, 8'h60);
    wr(8'h18, 8'h00);
    cy(2);
    #1 chk(8'(irq), 8'h00);
    rdc(8'h12, 8'h87);
    rdc(8'h13, 8'hD0);
    wr(8'h12, 8'hFF);
    rdc(8'h12, 8'h00);
    wr(8'h1A, 8'h40);
    cy(1);
    fan1 <= 1'b1;
    fan2 <= 1'b1;
    cy(1);
    fan1 <= 1'b0;
    fan2 <= 1'b0;
    cy(3);
    #1 chk(8'(irq), 8'h01);
    rdc(8'h14, 8'hC0);
    wr(8'h14, 8'h40);
    cy(2);
    #1 chk(8'(irq), 8'h00);
    rdc(8'h14, 8'h80);
    wr(8'h14, 8'h80);
    rdc(8'h14, 8'h00);
  endtask : t_irq
  task automatic fdd_set(input logic [1:0] s, input logic st, input logic c);
    cy(1);
    sel <= s;
    step <= st;
    chg <= c;
    cy(6);
  endtask : fdd_set
  task automatic t_force();
    wr(8'h1E, 8'h02);
    rdc(8'h1E, 8'h03);
    wr(8'h1E, 8'h00);
    rdc(8'h1E, 8'h03);
    fdd_set(2'h1, 1'b0, 1'b0);
    #1 chk(8'(media), 8'h01);
    fdd_set(2'h1, 1'b1, 1'b0);
    fdd_set(2'h1, 1'b0, 1'b0);
    rdc(8'h1E, 8'h02);
    chk(8'(media), 8'h00);
    fdd_set(2'h2, 1'b0, 1'b0);
    #1 chk(8'(media), 8'h01);
    fdd_set(2'h2, 1'b1, 1'b0);
    fdd_set(2'h2, 1'b0, 1'b1);
    rdc(8'h1E, 8'h00);
    chk(8'(media), 8'h01);
    fdd_set(2'h0, 1'b0, 1'b1);
    #1 chk(8'(media), 8'h00);
  endtask : t_force
  task automatic t_shadow();
    cy(1);
    fdc_wr <= '{wr: 1'b1, data: 8'hFF};
    ser_wr <= '{wr: 1'b1, data: 8'hFF};
    cy(1);
    fdc_wr.wr <= 1'b0;
    ser_wr.wr <= 1'b0;
    rdc(8'h1F, 8'hDF);
    rdc(8'h20, 8'hCF);
    wr(8'h1F, 8'h00);
    rdc(8'h1F, 8'hDF);
    cy(1);
    fdc_wr <= '{wr: 1'b1, data: 8'h5A};
    ser_wr <= '{wr: 1'b1, data: 8'h5A};
    cy(1);
    fdc_wr.wr <= 1'b0;
    ser_wr.wr <= 1'b0;
    rdc(8'h1F, 8'h5A);
    rdc(8'h20, 8'h4A);
    cy(1);
    main_rst_in <= 1'b1;
    cy(2);
    main_rst_in <= 1'b0;
    rdc(8'h1E, 8'h01);
    chk(8'(media), 8'h00);
    rdc(8'h1F, 8'h00);
    rdc(8'h20, 8'h00);
  endtask : t_shadow
  initial begin
    cy(8);
    rst_in <= 1'b0;
    main_rst_in <= 1'b0;
    t_reset();
    t_enables();
    t_misc();
    t_irq();
    t_force();
    t_shadow();
    conclude();
  end
endmodule : tb
bind rsm_regs rsm_regs_checker i_chk (.ref_clk_in, .rst_in, .main_rst_in, .bus_in, .rdata_out, .fdd_in,
  .group_irq_out, .mgmt_irq_pin_n_out, .serirq_mgmt_req_out, .pme_mgmt_req_out, .media_changed_bit_out);
